// [rclk_map.vh]
// register map, field positions, reset values and bus codes for the reference clock block
//
// Contract
// (RULE1) The reference clock is derived only from the system clock, in every oscillator setup.
// (RULE2) The module runs only while the module enable bit is one; zero disables it.
// (RULE3) The divided clock reaches the pin only when pin output enable and module enable are set.
// (RULE4) A 3-bit divide field: 000 undivided, 001..111 divide by 2,4,8,16,32,64,128.
// (RULE5) A 2-bit duty field: 11 is 75%, 10 is 50%, 01 is 25%, 00 holds low.
// (RULE6) Undivided setting passes the source duty cycle unless the 0% setting is chosen; the code holds the level high for any nonzero duty.
// (RULE7) At divide by 2, 25% and 75% accuracy depends on the source clock edges; the code gives 50% for 25% and holds high for 75%.
// (RULE8) Slew limiting on the pin is applied while the slew bit is one, removed when zero.
// (RULE9) Software wanting 20 MHz or more on the pin clears the slew limiting bit.
// (RULE10) Any device reset disables the module and returns the control register to defaults.
// (RULE11) Crystal-type oscillator modes block the pin output; the pin is an oscillator input.
// (RULE12) The clock-out option wins over the reference output and puts Fosc/4 on the pin.
// (RULE13) Reference clock reaches the pin only while the clock-out bit is one; zero gives Fosc/4.
// (RULE14) With the pin blocked, the module still enables and still feeds the modulator.
// (RULE15) The divided reference clock is a secondary clock source for the signal modulator.
// (RULE16) In Sleep the module stops and its outputs hold their levels until wake.
// (RULE17) After reset the control register reads slew limiting on, duty 10, all else zero.
// (RULE18) While disabled the divider counter is cleared and the output held low.
`ifndef RCLK_MAP_VH
`define RCLK_MAP_VH

// byte offsets of the registers
`define RCLK_CTRL_OFFSET 8'h00
`define RCLK_STAT_OFFSET 8'h04

// control register fields
`define RCLK_CTRL_EN_BIT 7
`define RCLK_CTRL_OE_BIT 6
`define RCLK_CTRL_SLR_BIT 5
`define RCLK_CTRL_DC_HI 4
`define RCLK_CTRL_DC_LO 3
`define RCLK_CTRL_DIV_HI 2
`define RCLK_CTRL_DIV_LO 0
`define RCLK_CTRL_RESET 8'h30

// status register fields
`define RCLK_STAT_REF_BIT 0
`define RCLK_STAT_DRIVE_BIT 1
`define RCLK_STAT_CLKOUT_BIT 2
`define RCLK_STAT_SLEEP_BIT 3
`define RCLK_STAT_XTAL_BIT 4

// bus response codes
`define RCLK_RESP_OKAY 2'h0
`define RCLK_RESP_SLVERR 2'h2

// system clock to pin clock-out ratio counter width (Fosc/4)
`define RCLK_FOSC4_W 2

`endif

// [rclk_gen.v]
// divider and duty-cycle shaper that makes the reference clock level
`timescale 1ns/1ns
module rclk_gen #(
  parameter CNT_W = 7
) (
  input wire core_clk,
  input wire sys_rst,
  input wire run,
  input wire hold,
  input wire [2:0] div_sel,
  input wire [1:0] duty_sel,
  output reg ref_level
);

  reg [CNT_W-1:0] cnt;
  wire [CNT_W:0] period;
  wire [CNT_W-1:0] last;
  wire [CNT_W+2:0] thr;
  wire [CNT_W-1:0] next_cnt;

  // period is 2^div core cycles, so 000 is undivided and 111 is /128 [RULE4]
  assign period = {{CNT_W{1'b0}}, 1'b1} << div_sel;
  assign last = period[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
  // high cycles = ceil(period * duty / 4); duty code is the quarter count [RULE5] [RULE7]
  assign thr = ({2'b00, period} * {{(CNT_W+1){1'b0}}, duty_sel} + {{CNT_W{1'b0}}, 3'h3}) >> 2;
  assign next_cnt = (cnt >= last) ? {CNT_W{1'b0}} : cnt + {{(CNT_W-1){1'b0}}, 1'b1};

  // counter runs on the system clock only; held in sleep, cleared when disabled
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= {CNT_W{1'b0}};
      ref_level <= 1'b0;
    end else if (hold) begin
      cnt <= cnt; // levels freeze while asleep [RULE16]
      ref_level <= ref_level;
    end else if (!run) begin
      cnt <= {CNT_W{1'b0}}; // clean restart on enable [RULE18] [RULE2]
      ref_level <= 1'b0;
    end else begin
      cnt <= next_cnt; // [RULE1]
      ref_level <= ({3'b000, next_cnt} < thr); // undivided: level held high for any nonzero duty, 0% low [RULE6]
    end
  end

endmodule

// [rclk_top.v]
// reference clock block: axi4-lite control slave, pin multiplexing and modulator clock
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "rclk_map.vh"
module rclk_top #(
  parameter ADDR_W = 8,
  parameter CNT_W = 7
) (
  input wire core_clk,
  input wire sys_rst,
  // axi4-lite write address channel
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data channel
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response channel
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address channel
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data channel
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // device state and configuration word
  input wire sleep_mode,
  input wire low_power_crystal_mode,
  input wire crystal_mode,
  input wire high_speed_crystal_mode,
  input wire cfg_sysclk_out_n,
  // pin and modulator side
  output reg ref_clock_out_pin,
  output reg ref_clock_out_pin_oe_n,
  output reg ref_slew_limit_enable,
  output wire modulator_ref_clk
);

  // control register and captured write halves
  reg [7:0] reference_clock_control;
  reg aw_held;
  reg [ADDR_W-1:0] aw_addr;
  reg w_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [`RCLK_FOSC4_W-1:0] fosc4_cnt;
  wire ref_level;
  wire xtal_mode;
  wire clkout_sel;
  wire ref_to_pin;
  wire pin_drive;
  wire next_pin_level;
  wire wr_fire;
  wire wr_ctrl;
  wire wr_known;
  wire rd_fire;
  wire [7:0] status_word;

  // word-aligned address decode, used by both channels
  function [1:0] reg_select;
    input [ADDR_W-1:0] addr;
    begin
      if (addr == `RCLK_CTRL_OFFSET)
        reg_select = 2'h1;
      else if (addr == `RCLK_STAT_OFFSET)
        reg_select = 2'h2;
      else
        reg_select = 2'h0;
    end
  endfunction

  // ---------------------------------------------------------------
  // write path: address and data taken independently, answer after both
  // ---------------------------------------------------------------

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_ctrl = (reg_select(aw_addr) == 2'h1);
  assign wr_known = (reg_select(aw_addr) != 2'h0);

  // write address capture
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      aw_addr <= {ADDR_W{1'b0}};
      s_axi_awready <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      // ready only while the slot is empty and not just filled
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
    end
  end

  // write data capture
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // write response: okay for the two mapped words, slverr elsewhere
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RCLK_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? `RCLK_RESP_OKAY : `RCLK_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RCLK_RESP_OKAY;
    end
  end

  // control register; only byte lane 0 carries it, status word is read-only
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reference_clock_control <= `RCLK_CTRL_RESET; // defaults, module off [RULE10] [RULE17]
    end else if (wr_fire && wr_ctrl && w_strb[0]) begin
      reference_clock_control <= w_data[7:0];
    end
  end

  // ---------------------------------------------------------------
  // read path: one read at a time, data one cycle after the address
  // ---------------------------------------------------------------

  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // live status: reference level, pin ownership, clock-out choice, sleep, crystal block
  assign status_word = {3'b000, xtal_mode, sleep_mode, clkout_sel, !ref_clock_out_pin_oe_n, ref_level};

  // read address accept
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire && !s_axi_arready;
    end
  end

  // read data and response
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RCLK_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      case (reg_select(s_axi_araddr))
        2'h1: begin
          s_axi_rdata <= {24'h00_0000, reference_clock_control};
          s_axi_rresp <= `RCLK_RESP_OKAY;
        end
        2'h2: begin
          s_axi_rdata <= {24'h00_0000, status_word};
          s_axi_rresp <= `RCLK_RESP_OKAY;
        end
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RCLK_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RCLK_RESP_OKAY;
    end
  end

  // ---------------------------------------------------------------
  // reference clock generation
  // ---------------------------------------------------------------

  // divider runs whenever enabled and not asleep, independent of the pin state [RULE2] [RULE14]
  rclk_gen #(
    .CNT_W(CNT_W)
  ) u_gen (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .run(reference_clock_control[`RCLK_CTRL_EN_BIT]),
    .hold(sleep_mode),
    .div_sel(reference_clock_control[`RCLK_CTRL_DIV_HI:`RCLK_CTRL_DIV_LO]),
    .duty_sel(reference_clock_control[`RCLK_CTRL_DC_HI:`RCLK_CTRL_DC_LO]),
    .ref_level(ref_level)
  );

  // modulator always gets the divided clock, even with the pin blocked [RULE15] [RULE14]
  assign modulator_ref_clk = ref_level;

  // ---------------------------------------------------------------
  // pin multiplexing
  // ---------------------------------------------------------------

  // crystal-type modes own the pin as an oscillator input [RULE11]
  assign xtal_mode = low_power_crystal_mode || crystal_mode || high_speed_crystal_mode;
  // clock-out option (active low bit) takes the pin for Fosc/4 [RULE12] [RULE13]
  assign clkout_sel = !cfg_sysclk_out_n;
  // reference reaches the pin only with both enables and no clock-out [RULE3] [RULE13]
  assign ref_to_pin = reference_clock_control[`RCLK_CTRL_EN_BIT]
                      && reference_clock_control[`RCLK_CTRL_OE_BIT] && !clkout_sel;
  assign pin_drive = !xtal_mode && (clkout_sel || ref_to_pin); // [RULE11]
  assign next_pin_level = clkout_sel ? fosc4_cnt[`RCLK_FOSC4_W-1] : (ref_to_pin && ref_level);

  // system clock divided by four for the clock-out function
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fosc4_cnt <= {`RCLK_FOSC4_W{1'b0}};
    end else if (!sleep_mode) begin
      fosc4_cnt <= fosc4_cnt + {{(`RCLK_FOSC4_W-1){1'b0}}, 1'b1}; // [RULE12]
    end
  end

  // pin level, enable and slew control, frozen while asleep
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_clock_out_pin <= 1'b0;
      ref_clock_out_pin_oe_n <= 1'b1;
      ref_slew_limit_enable <= 1'b1;
    end else if (sleep_mode) begin
      ref_clock_out_pin <= ref_clock_out_pin; // [RULE16]
      ref_clock_out_pin_oe_n <= ref_clock_out_pin_oe_n;
      ref_slew_limit_enable <= ref_slew_limit_enable;
    end else begin
      ref_clock_out_pin <= pin_drive && next_pin_level;
      ref_clock_out_pin_oe_n <= !pin_drive; // low while driving
      ref_slew_limit_enable <= reference_clock_control[`RCLK_CTRL_SLR_BIT]; // [RULE8]
    end
  end

endmodule

// [rclk_assertions.sv]
// checker watching the reference clock block ports
`timescale 1ns/1ns
module rclk_assertions (
  input wire core_clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid, sleep_mode, cfg_sysclk_out_n,
  input wire low_power_crystal_mode, crystal_mode, high_speed_crystal_mode,
  input wire ref_clock_out_pin, ref_clock_out_pin_oe_n, ref_slew_limit_enable, modulator_ref_clk
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // shorthands for the pin mux conditions
  wire xtal = low_power_crystal_mode | crystal_mode | high_speed_crystal_mode;
  wire fosc4 = !xtal && !cfg_sysclk_out_n && !sleep_mode;
  wire pin = ref_clock_out_pin;
  wire oe_n = ref_clock_out_pin_oe_n;
  wire mod = modulator_ref_clk;
  a_reset_state: assert property (disable iff (1'b0) sys_rst |-> ref_slew_limit_enable && oe_n && !pin && !mod)
    else $error("outputs wrong in reset");
  a_xtal_blocks: assert property (xtal && !sleep_mode |=> oe_n)
    else $error("pin driven in crystal mode");
  a_clkout_wins: assert property (fosc4 |=> !oe_n)
    else $error("clock-out not driven");
  a_fosc4_rate: assert property (fosc4 [*4] |-> pin != $past(pin, 2))
    else $error("clock-out not a quarter rate");
  a_ref_route: assert property ($past(cfg_sysclk_out_n && !xtal && !sleep_mode) && !oe_n |-> pin == $past(mod))
    else $error("pin does not follow reference");
  a_idle_low: assert property (oe_n |-> !pin)
    else $error("undriven pin not low");
  a_sleep_hold: assert property (sleep_mode |=> $stable(pin) && $stable(oe_n) && $stable(mod))
    else $error("outputs moved in sleep");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  c_clkout: cover property (fosc4 [*4]);
  c_sleep: cover property (sleep_mode && !oe_n);
  c_ref_pin: cover property (cfg_sysclk_out_n && !oe_n);
endmodule
bind rclk_top rclk_assertions u_rclk_assertions (.core_clk(core_clk), .sys_rst(sys_rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .sleep_mode(sleep_mode),
  .cfg_sysclk_out_n(cfg_sysclk_out_n), .low_power_crystal_mode(low_power_crystal_mode),
  .crystal_mode(crystal_mode), .high_speed_crystal_mode(high_speed_crystal_mode),
  .ref_clock_out_pin(ref_clock_out_pin), .ref_clock_out_pin_oe_n(ref_clock_out_pin_oe_n),
  .ref_slew_limit_enable(ref_slew_limit_enable), .modulator_ref_clk(modulator_ref_clk));

// [rclk_ext_dev.sv]
// far-side model: a receiver counting high samples and rising edges of a clock
`timescale 1ns/1ns
module rclk_ext_dev (
  input wire core_clk,
  input wire clr,
  input wire lvl,
  input wire vld,
  output reg [15:0] hi_cnt,
  output reg [15:0] rise_cnt
);
  reg prev = 1'b0;
  // an undriven pin reads low, as through a pull-down
  wire seen = vld & lvl;
  // counts over a window opened by clr
  always @(posedge core_clk) begin
    prev <= seen;
    hi_cnt <= clr ? 16'h0 : hi_cnt + {15'h0, seen};
    rise_cnt <= clr ? 16'h0 : rise_cnt + {15'h0, seen & ~prev};
  end
endmodule

// [rclk_top_tb.sv]
// self-checking bench for the reference clock block
`timescale 1ns/1ns
module rclk_top_tb;
  reg core_clk = 1'b0;
  reg sys_rst = 1'b0;
  reg aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0, mv = 1'b0, clr = 1'b0;
  reg slp = 1'b0, lp = 1'b0, xt = 1'b0, hs = 1'b0, cfg = 1'b1;
  reg [7:0] aw_a = 8'h00, ar_a = 8'h00;
  reg [3:0] ws = 4'hF;
  reg [31:0] w_d = 32'h0, rnd = 32'h0;
  reg [33:0] mval = 34'h0;
  wire aw_r, w_r, b_v, ar_r, r_v, pin, oe_n, slew, mod;
  wire [1:0] b_resp, r_resp;
  wire [31:0] r_d;
  wire [15:0] mh, mr, ph, pr;
  logic [33:0] eq[$];
  string nq[$];
  integer n_fail = 0, n_checks = 0, d, c;
  rclk_top u_rclk_top (.core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(ws), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .sleep_mode(slp), .low_power_crystal_mode(lp), .crystal_mode(xt), .high_speed_crystal_mode(hs),
    .cfg_sysclk_out_n(cfg), .ref_clock_out_pin(pin), .ref_clock_out_pin_oe_n(oe_n),
    .ref_slew_limit_enable(slew), .modulator_ref_clk(mod));
  rclk_ext_dev u_mod_dev (.core_clk(core_clk), .clr(clr), .lvl(mod), .vld(1'b1), .hi_cnt(mh), .rise_cnt(mr));
  rclk_ext_dev u_pin_dev (.core_clk(core_clk), .clr(clr), .lvl(pin), .vld(~oe_n), .hi_cnt(ph), .rise_cnt(pr));
  initial forever #50 core_clk = ~core_clk;
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input [33:0] got);
    reg [33:0] e;
    string n;
    e = eq.pop_front();
    n = nq.pop_front();
    n_checks = n_checks + 1;
    if (got !== e) begin
      n_fail = n_fail + 1;
      $display("[ERR] %s expected %h seen %h", n, e, got);
    end
  endtask
  // compares every result that appears with the oldest note
  always @(posedge core_clk) begin
    if (b_v && b_r) chk({32'h0, b_resp});
    if (r_v && r_r) chk({r_resp, r_d});
    if (mv) chk(mval);
  end
  task note(input string n, input [33:0] e, input [33:0] g);
    eq.push_back(e);
    nq.push_back(n);
    mval <= g;
    mv <= 1'b1;
    @(posedge core_clk);
    mv <= 1'b0;
  endtask
  task wr(input [7:0] a, input [31:0] v, input [1:0] r);
    eq.push_back({32'h0, r});
    nq.push_back("bresp");
    aw_a <= a;
    w_d <= v;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    do begin
      @(posedge core_clk);
      if (aw_r) aw_v <= 1'b0;
      if (w_r) w_v <= 1'b0;
    end while (!b_v);
    b_r <= 1'b0;
  endtask
  task rd(input [7:0] a, input [1:0] r, input [31:0] v);
    eq.push_back({r, v});
    nq.push_back("rdata");
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do begin
      @(posedge core_clk);
      if (ar_r) ar_v <= 1'b0;
    end while (!r_v);
    r_r <= 1'b0;
  endtask
  // highs and rising edges over 256 cycles for a divide and duty code
  function [31:0] expv(input [2:0] dv, input [1:0] cv);
    integer p;
    integer h;
    begin
      p = 1 << dv;
      h = (p * cv + 3) / 4;
      expv = {16'(256 / p * h), 16'((h == 0 || h == p) ? 0 : 256 / p)};
    end
  endfunction
  task meas(input string n, input sel, input [31:0] e);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    repeat (257) @(posedge core_clk);
    note(n, {2'b00, e}, sel ? {2'b00, ph, pr} : {2'b00, mh, mr});
  endtask
  // main sequence
  initial begin
    d = $urandom(32'h2a8f790a);
    sys_rst <= 1'b1; // edge at time zero so the design resets before the first clock
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(8'h00, 2'h0, 32'h30);
    rnd = $urandom;
    wr(8'h10, rnd, 2'h2);
    rd(8'h10, 2'h2, 32'h0);
    for (d = 0; d < 8; d = d + 1) begin
      for (c = 0; c < 4; c = c + 1) begin
        rnd = $urandom;
        wr(8'h00, {rnd[31:8], 3'b101, c[1:0], d[2:0]}, 2'h0);
        repeat (130) @(posedge core_clk);
        meas("modulator", 1'b0, expv(d[2:0], c[1:0]));
      end
    end
    rd(8'h00, 2'h0, 32'hBF);
    // a write without byte lane 0 must leave the control byte alone
    ws <= 4'hE;
    wr(8'h00, 32'h00, 2'h0);
    ws <= 4'hF;
    rd(8'h00, 2'h0, 32'hBF);
    wr(8'h00, 32'hCB, 2'h0);
    repeat (130) @(posedge core_clk);
    meas("pin", 1'b1, expv(3'h3, 2'h1));
    @(posedge core_clk);
    note("slew", 34'h0, {33'h0, slew});
    cfg <= 1'b0;
    repeat (4) @(posedge core_clk);
    meas("clock-out", 1'b1, 32'h00800040);
    cfg <= 1'b1;
    for (d = 0; d < 3; d = d + 1) begin
      lp <= (d == 0);
      xt <= (d == 1);
      hs <= (d == 2);
      meas("crystal pin", 1'b1, 32'h0);
      meas("crystal modulator", 1'b0, expv(3'h3, 2'h1));
    end
    lp <= 1'b0;
    xt <= 1'b0;
    hs <= 1'b0;
    repeat (4) @(posedge core_clk);
    slp <= 1'b1;
    @(posedge core_clk);
    // the driven pin must keep its level for the whole sleep window
    meas("sleep pin", 1'b1, {(pin ? 16'h0100 : 16'h0000), 16'h0000});
    slp <= 1'b0;
    wr(8'h00, 32'h38, 2'h0);
    meas("disabled", 1'b0, 32'h0);
    // status: crystal mode and clock-out seen, pin not driven, reference low
    xt <= 1'b1;
    cfg <= 1'b0;
    rd(8'h04, 2'h0, 32'h14);
    xt <= 1'b0;
    cfg <= 1'b1;
    wr(8'h00, 32'hFF, 2'h0);
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(8'h00, 2'h0, 32'h30);
    meas("after reset", 1'b0, 32'h0);
    end_of_test;
  end
  // watchdog against a hang
  initial begin
    repeat (40000) @(posedge core_clk);
    n_fail = n_fail + 1;
    end_of_test;
  end
endmodule
